/* File: rtl/rtct_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtct_map.svh"
module rtct_timer #(
   parameter int TIMER_CLOCK_DIV = `RTCT_TIMER_CLOCK_DIV,
   parameter int BAUD_DIV = `RTCT_BAUD_DIV
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [`RTCT_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] timer_pin_i,
   output logic [2:0] timer_pin_o,
   output logic [2:0] timer_pin_oe_n,
   input wire logic [2:0] port_pin_o,
   input wire logic [2:0] port_pin_oe_n,
   input wire logic [1:0] other_timer_overflow,
   output logic [1:0] other_timer_count,
   input wire logic direction_trigger_pin,
   input wire logic uart_default_tick,
   output logic [3:0] uart_baud_tick,
   output logic event_request,
   output rtct_pkg::rtct_count_t count_value
);
   import rtct_pkg::*;

   localparam int TW = (TIMER_CLOCK_DIV > 1) ? $clog2(TIMER_CLOCK_DIV) : 1;

   logic [7:0] pin_ctrl_reg;
   logic [7:0] mode_ctrl_reg;
   logic [7:0] main_ctrl_reg;
   logic [7:0] main_ctrl_next;
   rtct_count_t cnt_reg;
   rtct_count_t cnt_next;
   rtct_count_t reload_reg;
   rtct_count_t reload_next;
   logic [TW-1:0] tdiv_reg;
   logic trig_d_reg;
   logic [7:0] rdata_next;
   rtct_mode_t mode;
   logic t2_baud_tick;

   rtct_chan_if ch[3] ();

   // Register decode
   wire wr_pin = reg_wr && (reg_addr == `RTCT_OFS_PIN_CTRL);
   wire wr_mode = reg_wr && (reg_addr == `RTCT_OFS_MODE_CTRL);
   wire wr_main = reg_wr && (reg_addr == `RTCT_OFS_MAIN_CTRL);
   wire wr_cnt_lo = reg_wr && (reg_addr == `RTCT_OFS_CNT_LO);
   wire wr_cnt_hi = reg_wr && (reg_addr == `RTCT_OFS_CNT_HI);
   wire wr_rld_lo = reg_wr && (reg_addr == `RTCT_OFS_RLD_LO);
   wire wr_rld_hi = reg_wr && (reg_addr == `RTCT_OFS_RLD_HI);
   wire sw_touch = wr_main || wr_mode || wr_cnt_lo || wr_cnt_hi || wr_rld_lo || wr_rld_hi;

   // Control fields
   wire run = main_ctrl_reg[`RTCT_MAIN_RUN];
   wire ct_sel = main_ctrl_reg[`RTCT_MAIN_CT];
   wire cap_sel = main_ctrl_reg[`RTCT_MAIN_CAP];
   wire ext_en = main_ctrl_reg[`RTCT_MAIN_EXEN];
   wire ovf_flag = main_ctrl_reg[`RTCT_MAIN_OVF];
   wire ext_flag = main_ctrl_reg[`RTCT_MAIN_EXTF];
   wire dir_en = mode_ctrl_reg[`RTCT_MODE_DIR_EN];
   wire pin_oe = mode_ctrl_reg[`RTCT_MODE_PIN_OE];
   wire [3:0] baud_sel = {mode_ctrl_reg[`RTCT_MODE_UB_TX],
                          mode_ctrl_reg[`RTCT_MODE_UB_RX],
                          main_ctrl_reg[`RTCT_MAIN_UA_TX],
                          main_ctrl_reg[`RTCT_MAIN_UA_RX]};
   wire any_baud = |baud_sel;

   // Mode priority: stop, then baud, then capture, then reload flavour
   assign mode = !run ? RTCT_STOP :
                 any_baud ? RTCT_BAUD :
                 cap_sel ? RTCT_CAPTURE :
                 dir_en ? RTCT_RELOAD_UPDN : RTCT_RELOAD_UP;

   // Timer clock as an enable pulse
   wire timer_clock_en = (tdiv_reg == '0);
   wire last_tdiv = (tdiv_reg == TW'(TIMER_CLOCK_DIV - 1));

   // Baud mode always uses the timer clock, never the pin
   wire use_timer_clock = (mode == RTCT_BAUD) || !ct_sel;
   wire step = (mode != RTCT_STOP) &&
               (use_timer_clock ? timer_clock_en : ch[2].count_fall);
   wire count_down = (mode == RTCT_RELOAD_UPDN) && !direction_trigger_pin;
   wire at_top = (cnt_reg == `RTCT_ALL_ONES);
   wire at_reload = (cnt_reg == reload_reg);
   wire ovf = step && !count_down && at_top;
   wire udf = step && count_down && at_reload;
   wire roll = ovf || udf;

   // Trigger pin falls; the pin is the direction in up/down mode
   wire trig_fall = trig_d_reg && !direction_trigger_pin;
   wire ext_event = ext_en && trig_fall &&
                    ((mode == RTCT_CAPTURE) || (mode == RTCT_RELOAD_UP));
   wire ext_reload = ext_event && (mode == RTCT_RELOAD_UP);
   wire do_capture = ext_event && (mode == RTCT_CAPTURE);
   wire updn_toggle = (mode == RTCT_RELOAD_UPDN) && roll;
   // Rollovers feeding a baud clock or the clock pin stay quiet
   wire ovf_set = roll && (mode != RTCT_BAUD) && !pin_oe;
   wire [15:0] step_val = count_down ? (cnt_reg - 16'h0001) : (cnt_reg + 16'h0001);

   always_comb begin
      cnt_next = cnt_reg;
      if (udf) begin
         cnt_next = `RTCT_ALL_ONES;
      end else if ((ovf && (mode != RTCT_CAPTURE)) || ext_reload) begin
         cnt_next = reload_reg;
      end else if (step) begin
         cnt_next = step_val;
      end
      // Software writes to the count take the last word
      if (wr_cnt_lo) begin
         cnt_next[7:0] = reg_wdata;
      end
      if (wr_cnt_hi) begin
         cnt_next[15:8] = reg_wdata;
      end
   end

   always_comb begin
      reload_next = reload_reg;
      if (wr_rld_lo) begin
         reload_next[7:0] = reg_wdata;
      end
      if (wr_rld_hi) begin
         reload_next[15:8] = reg_wdata;
      end
      // A capture must not be lost to a racing write
      if (do_capture) begin
         reload_next = cnt_reg;
      end
   end

   always_comb begin
      main_ctrl_next = main_ctrl_reg;
      if (wr_main) begin
         main_ctrl_next = reg_wdata;
      end
      // Hardware set beats a software clear in the same cycle
      if (ovf_set) begin
         main_ctrl_next[`RTCT_MAIN_OVF] = 1'b1;
      end
      if (updn_toggle) begin
         main_ctrl_next[`RTCT_MAIN_EXTF] = ~ext_flag;
      end else if (ext_event) begin
         main_ctrl_next[`RTCT_MAIN_EXTF] = 1'b1;
      end
   end

   always_comb begin
      unique case (reg_addr)
         `RTCT_OFS_PIN_CTRL: rdata_next = pin_ctrl_reg;
         `RTCT_OFS_MODE_CTRL: rdata_next = mode_ctrl_reg;
         `RTCT_OFS_MAIN_CTRL: rdata_next = main_ctrl_reg;
         `RTCT_OFS_CNT_LO: rdata_next = cnt_reg[7:0];
         `RTCT_OFS_CNT_HI: rdata_next = cnt_reg[15:8];
         `RTCT_OFS_RLD_LO: rdata_next = reload_reg[7:0];
         `RTCT_OFS_RLD_HI: rdata_next = reload_reg[15:8];
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_ctrl_reg <= `RTCT_RST_BYTE;
         mode_ctrl_reg <= `RTCT_RST_BYTE;
         main_ctrl_reg <= `RTCT_RST_BYTE;
         cnt_reg <= 16'h0000;
         reload_reg <= 16'h0000;
         tdiv_reg <= '0;
         trig_d_reg <= 1'b1;
         reg_rdata <= 8'h00;
      end else begin
         if (wr_pin) begin
            pin_ctrl_reg <= reg_wdata & `RTCT_PIN_CTRL_MASK;
         end
         if (wr_mode) begin
            mode_ctrl_reg <= reg_wdata & `RTCT_MODE_CTRL_MASK;
         end
         main_ctrl_reg <= main_ctrl_next;
         cnt_reg <= cnt_next;
         reload_reg <= reload_next;
         tdiv_reg <= last_tdiv ? '0 : tdiv_reg + 1'b1;
         trig_d_reg <= direction_trigger_pin;
         reg_rdata <= reg_rd ? rdata_next : 8'h00;
      end
   end

   // Pin channels: first timer, second timer, this timer's shared pin
   assign ch[0].overflow = other_timer_overflow[0];
   assign ch[0].out_enable = pin_ctrl_reg[`RTCT_PIN_T0_OE];
   assign ch[1].overflow = other_timer_overflow[1];
   assign ch[1].out_enable = pin_ctrl_reg[`RTCT_PIN_T1_OE];
   assign ch[2].overflow = roll;
   assign ch[2].out_enable = pin_oe;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_chan
         assign ch[gi].pin_i = timer_pin_i[gi];
         assign ch[gi].port_o = port_pin_o[gi];
         assign ch[gi].port_oe_n = port_pin_oe_n[gi];
         assign timer_pin_o[gi] = ch[gi].pin_o;
         assign timer_pin_oe_n[gi] = ch[gi].pin_oe_n;
         rtct_pin_chan u_chan (
            .sys_clk(sys_clk),
            .rst(rst),
            .bus(ch[gi])
         );
      end
   endgenerate

   assign other_timer_count = {ch[1].count_fall, ch[0].count_fall};

   rtct_baud_div #(
      .DIV(BAUD_DIV)
   ) u_baud (
      .sys_clk(sys_clk),
      .rst(rst),
      .overflow(roll && (mode == RTCT_BAUD)),
      .baud_tick(t2_baud_tick)
   );

   // Each direction of each UART picks its own source
   assign uart_baud_tick = (baud_sel & {4{t2_baud_tick}}) |
                           (~baud_sel & {4{uart_default_tick}});
   assign event_request = ovf_flag ||
                          (ext_flag && (mode != RTCT_RELOAD_UPDN));
   assign count_value = cnt_reg;

   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   chk_down_underflow_load: assert property (
      udf && !wr_cnt_lo && !wr_cnt_hi |=> cnt_reg == 16'hFFFF)
      else $error("underflow did not load all ones");

   chk_underflow_flag_set: assert property (
      udf && !pin_oe |=> ovf_flag && event_request)
      else $error("underflow did not set overflow flag");

   chk_ext_flag_toggle: assert property (
      updn_toggle |=> ext_flag != $past(ext_flag))
      else $error("external flag did not toggle on rollover");

   chk_updn_quiet_req: assert property (
      mode == RTCT_RELOAD_UPDN && !ovf_flag |-> !event_request)
      else $error("up/down flag change raised a request");

   chk_baud_step_rate: assert property (
      mode == RTCT_BAUD && !sw_touch && reload_reg != 16'hFFFF ##1 mode == RTCT_BAUD && !sw_touch
      |-> (cnt_reg != $past(cnt_reg)) == $past(timer_clock_en))
      else $error("baud mode step not tied to timer clock");

   chk_baud_route_sel: assert property (
      t2_baud_tick && !uart_default_tick |-> uart_baud_tick == baud_sel)
      else $error("baud tick not routed by select");

   chk_clkout_toggle: assert property (
      pin_oe && roll && !wr_mode |=> timer_pin_o[2] != $past(timer_pin_o[2]))
      else $error("clock pin did not toggle on rollover");

   chk_clkout_no_flag: assert property (
      pin_oe && roll && !ovf_flag && !wr_main |=> !ovf_flag)
      else $error("clock-out rollover set the flag");

   chk_stop_holds: assert property (
      mode == RTCT_STOP && !wr_cnt_lo && !wr_cnt_hi |=> cnt_reg == $past(cnt_reg))
      else $error("stopped timer changed count");

   chk_up_reload: assert property (
      ovf && mode != RTCT_CAPTURE && !sw_touch |=> cnt_reg == $past(reload_reg) && (
         $past(mode) == RTCT_BAUD || $past(pin_oe) || ovf_flag))
      else $error("overflow did not reload or flag");

   chk_route_indep: assert property (
      !t2_baud_tick && uart_default_tick |-> uart_baud_tick == ~baud_sel)
      else $error("unselected direction lost its default tick");

   chk_shared_pin_port: assert property (
      !pin_oe |-> timer_pin_o[2] == port_pin_o[2] && timer_pin_oe_n[2] == port_pin_oe_n[2])
      else $error("shared pin does not follow the port");

   chk_clock_pin_drive: assert property (
      pin_oe |-> !timer_pin_oe_n[2])
      else $error("clock pin not driven");

   chk_first_pin_toggle: assert property (
      pin_ctrl_reg[`RTCT_PIN_T0_OE] && other_timer_overflow[0] && !wr_pin
      |=> timer_pin_o[0] != $past(timer_pin_o[0]))
      else $error("first timer pin did not toggle");

   chk_second_pin_toggle: assert property (
      pin_ctrl_reg[`RTCT_PIN_T1_OE] && other_timer_overflow[1] && !wr_pin
      |=> timer_pin_o[1] != $past(timer_pin_o[1]))
      else $error("second timer pin did not toggle");

   chk_baud_tick_source: assert property (
      t2_baud_tick |-> $past(roll) && $past(mode) == RTCT_BAUD)
      else $error("baud tick without a baud rollover");

   chk_capture_copy: assert property (
      do_capture |=> reload_reg == $past(cnt_reg))
      else $error("capture did not copy the count");

   // Step checks leave out software count writes, which win by design
   chk_up_step: assert property (
      step && !count_down && !at_top && !ext_reload && !wr_cnt_lo && !wr_cnt_hi
      |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("up step did not add one");

   chk_down_step: assert property (
      step && count_down && !at_reload && !wr_cnt_lo && !wr_cnt_hi
      |=> cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("down step did not take one");
endmodule : rtct_timer
`default_nettype wire

/* File: shared/rtct_map.svh */
`ifndef RTCT_MAP_SVH
`define RTCT_MAP_SVH
`define RTCT_ADDR_W 12
`define RTCT_OFS_PIN_CTRL 12'h411
`define RTCT_OFS_CNT_LO 12'h412
`define RTCT_OFS_CNT_HI 12'h413
`define RTCT_OFS_RLD_LO 12'h414
`define RTCT_OFS_RLD_HI 12'h415
`define RTCT_OFS_MAIN_CTRL 12'h418
`define RTCT_OFS_MODE_CTRL 12'h419
`define RTCT_MAIN_OVF 7
`define RTCT_MAIN_EXTF 6
`define RTCT_MAIN_UA_RX 5
`define RTCT_MAIN_UA_TX 4
`define RTCT_MAIN_EXEN 3
`define RTCT_MAIN_RUN 2
`define RTCT_MAIN_CT 1
`define RTCT_MAIN_CAP 0
`define RTCT_MODE_UB_RX 5
`define RTCT_MODE_UB_TX 4
`define RTCT_MODE_PIN_OE 1
`define RTCT_MODE_DIR_EN 0
`define RTCT_PIN_T1_OE 2
`define RTCT_PIN_T0_OE 0
`define RTCT_RST_BYTE 8'h00
`define RTCT_PIN_CTRL_MASK 8'h05
`define RTCT_MODE_CTRL_MASK 8'h33
`define RTCT_ALL_ONES 16'hFFFF
`define RTCT_TIMER_CLOCK_DIV 4
`define RTCT_BAUD_DIV 16
`endif

/* File: shared/rtct_pkg.sv */
package rtct_pkg;
   typedef enum logic [2:0] {
      RTCT_STOP,
      RTCT_BAUD,
      RTCT_CAPTURE,
      RTCT_RELOAD_UP,
      RTCT_RELOAD_UPDN
   } rtct_mode_t;
   typedef logic [15:0] rtct_count_t;
endpackage : rtct_pkg

/* File: shared/rtct_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rtct_chan_if;
   logic overflow;
   logic out_enable;
   logic count_fall;
   logic pin_i;
   logic pin_o;
   logic pin_oe_n;
   logic port_o;
   logic port_oe_n;
   modport chan (input overflow, out_enable, pin_i, port_o, port_oe_n,
                 output count_fall, pin_o, pin_oe_n);
   modport core (output overflow, out_enable, pin_i, port_o, port_oe_n,
                 input count_fall, pin_o, pin_oe_n);
endinterface : rtct_chan_if
`default_nettype wire

/* File: rtl/rtct_pin_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module rtct_pin_chan (
   input wire logic sys_clk,
   input wire logic rst,
   rtct_chan_if.chan bus
);
   import rtct_pkg::*;
   logic pin_d_reg;
   logic toggle_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_d_reg <= 1'b1;
         toggle_reg <= 1'b0;
      end else begin
         pin_d_reg <= bus.pin_i;
         if (bus.overflow && bus.out_enable) begin
            toggle_reg <= ~toggle_reg;
         end
      end
   end

   // Input mode: falling edge counts; output mode: toggle per overflow
   assign bus.count_fall = !bus.out_enable && pin_d_reg && !bus.pin_i;
   assign bus.pin_o = bus.out_enable ? toggle_reg : bus.port_o;
   assign bus.pin_oe_n = bus.out_enable ? 1'b0 : bus.port_oe_n;
endmodule : rtct_pin_chan
`default_nettype wire

/* File: rtl/rtct_baud_div.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtct_map.svh"
module rtct_baud_div #(
   parameter int DIV = `RTCT_BAUD_DIV
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic overflow,
   output logic baud_tick
);
   import rtct_pkg::*;
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   logic [W-1:0] div_reg;
   wire div_last = (div_reg == W'(DIV - 1));

   // Sixteen overflows per bit time: twice the clock-out half periods times eight
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_reg <= '0;
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= overflow && div_last;
         if (overflow) begin
            div_reg <= div_last ? '0 : div_reg + 1'b1;
         end
      end
   end
endmodule : rtct_baud_div
`default_nettype wire

/* File: sim/rtct_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtct_pins_model (
   input wire logic [2:0] pin_o,
   input wire logic [2:0] pin_oe_n,
   input wire logic [2:0] ext_drive,
   input wire logic dir_up,
   output logic [2:0] pin_i,
   output logic dir_pin
);
   // A pin shows the design's value while it drives, otherwise the outside source
   assign pin_i = (pin_o & ~pin_oe_n) | (ext_drive & pin_oe_n);
   assign dir_pin = dir_up;
endmodule : rtct_pins_model
`default_nettype wire

/* File: sim/rtct_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtct_map.svh"
module rtct_timer_tb;
   import rtct_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [`RTCT_ADDR_W-1:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] pin_i, pin_o, pin_oe_n;
   logic [2:0] port_o = 3'b101;
   logic [2:0] port_oe_n = 3'b111;
   logic [2:0] ext_drive = 3'b111;
   logic dir_up = 1'b1;
   logic dir_pin;
   logic [1:0] other_ovf = 2'b00;
   logic [1:0] other_cnt;
   logic dflt_tick = 1'b0;
   logic [3:0] baud_tick;
   logic event_request;
   rtct_count_t count_value;
   rtct_count_t c;
   logic [7:0] d;
   logic [1:0] p;
   logic [15:0] tg, t0, t3, m;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;

   always #2 sys_clk = ~sys_clk;
   // Default tick changes every cycle so a wrong routing shows at once
   always @(posedge sys_clk) dflt_tick <= ~dflt_tick;

   rtct_timer #(.TIMER_CLOCK_DIV(1), .BAUD_DIV(16)) dut (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timer_pin_i(pin_i), .timer_pin_o(pin_o), .timer_pin_oe_n(pin_oe_n),
      .port_pin_o(port_o), .port_pin_oe_n(port_oe_n), .other_timer_overflow(other_ovf),
      .other_timer_count(other_cnt), .direction_trigger_pin(dir_pin),
      .uart_default_tick(dflt_tick), .uart_baud_tick(baud_tick),
      .event_request(event_request), .count_value(count_value));

   rtct_pins_model pins (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_drive(ext_drive),
      .dir_up(dir_up), .pin_i(pin_i), .dir_pin(dir_pin));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi,
                      input string msg);
      chk(16'(v >= lo && v <= hi), 16'h0001, msg);
   endtask : rng

   task automatic wr(input logic [`RTCT_ADDR_W-1:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [`RTCT_ADDR_W-1:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic wait_flag(input int b);
      for (int i = 0; i < 100; i++) begin
         rd(`RTCT_OFS_MAIN_CTRL);
         if (d[b] === 1'b1) return;
      end
      chk(16'h0000, 16'h0001, "flag never set");
   endtask : wait_flag

   task automatic watch(input int n);
      logic q;
      tg = 16'h0000;
      t0 = 16'h0000;
      t3 = 16'h0000;
      m = 16'h0000;
      q = pin_o[2];
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         if (pin_o[2] !== q) tg++;
         q = pin_o[2];
         if (baud_tick[0] === 1'b1) t0++;
         if (baud_tick[3] === 1'b1) t3++;
         if (baud_tick[2:1] !== {2{dflt_tick}}) m++;
      end
   endtask : watch

   task automatic report_and_stop;
      $display("mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`RTCT_OFS_PIN_CTRL);
      chk(16'(d), 16'h0000, "pin ctrl reset");
      rd(`RTCT_OFS_MODE_CTRL);
      chk(16'(d), 16'h0000, "mode ctrl reset");
      chk(16'(pin_o), 16'(port_o), "port passthrough");
      wr(12'h400, 8'hFF);
      rd(12'h400);
      chk(16'(d), 16'h0000, "unmapped read");
      wr(`RTCT_OFS_MODE_CTRL, 8'hFF);
      rd(`RTCT_OFS_MODE_CTRL);
      chk(16'(d), 16'h0033, "mode ctrl bits");
      wr(`RTCT_OFS_MODE_CTRL, 8'h00);
      wr(`RTCT_OFS_PIN_CTRL, 8'hFF);
      rd(`RTCT_OFS_PIN_CTRL);
      chk(16'(d), 16'h0005, "pin ctrl bits");
      p = pin_o[1:0];
      @(posedge sys_clk) other_ovf <= 2'b11;
      @(posedge sys_clk) other_ovf <= 2'b00;
      @(posedge sys_clk) #1;
      chk({14'h0000, pin_o[1:0]}, {14'h0000, ~p}, "overflow toggle");
      chk(16'(pin_oe_n[1:0]), 16'h0000, "timer pins driven");
      wr(`RTCT_OFS_PIN_CTRL, 8'h00);
      @(posedge sys_clk);
      @(posedge sys_clk) ext_drive[1] <= 1'b0;
      #1 chk(16'(other_cnt), 16'h0002, "pin fall counts");
      ext_drive[1] <= 1'b1;
      // Up-only reload: overflow lands on the reload value
      wr(`RTCT_OFS_RLD_LO, 8'h00);
      wr(`RTCT_OFS_RLD_HI, 8'h12);
      wr(`RTCT_OFS_CNT_LO, 8'hF0);
      wr(`RTCT_OFS_CNT_HI, 8'hFF);
      wr(`RTCT_OFS_MAIN_CTRL, 8'h04);
      wait_flag(`RTCT_MAIN_OVF);
      rng(count_value, 16'h1200, 16'h1240, "reload on overflow");
      chk(16'(event_request), 16'h0001, "overflow request");
      wr(`RTCT_OFS_MAIN_CTRL, 8'h00);
      @(posedge sys_clk) #1 c = count_value;
      repeat (8) @(posedge sys_clk);
      #1 chk(count_value, c, "stopped count");
      chk(16'(event_request), 16'h0000, "flag cleared");
      // Down count from just above the reload value
      wr(`RTCT_OFS_MODE_CTRL, 8'h01);
      dir_up <= 1'b0;
      wr(`RTCT_OFS_RLD_LO, 8'h10);
      wr(`RTCT_OFS_RLD_HI, 8'h00);
      wr(`RTCT_OFS_CNT_LO, 8'h30);
      wr(`RTCT_OFS_CNT_HI, 8'h00);
      wr(`RTCT_OFS_MAIN_CTRL, 8'h04);
      wait_flag(`RTCT_MAIN_OVF);
      rng(count_value, 16'hFF00, 16'hFFFF, "all ones on underflow");
      rd(`RTCT_OFS_MAIN_CTRL);
      chk(16'(d[6]), 16'h0001, "external flag toggled");
      wr(`RTCT_OFS_MAIN_CTRL, 8'h44);
      repeat (2) @(posedge sys_clk);
      #1 chk(16'(event_request), 16'h0000, "external flag silent");
      wr(`RTCT_OFS_MAIN_CTRL, 8'h00);
      dir_up <= 1'b1;
      // Capture on a trigger fall: the count lands in the reload pair
      wr(`RTCT_OFS_CNT_LO, 8'h00);
      wr(`RTCT_OFS_CNT_HI, 8'h01);
      wr(`RTCT_OFS_MAIN_CTRL, 8'h0D);
      dir_up <= 1'b0;
      rd(`RTCT_OFS_RLD_LO);
      c[7:0] = d;
      rd(`RTCT_OFS_RLD_HI);
      c[15:8] = d;
      rng(c, 16'h0100, 16'h0104, "captured count");
      chk(16'(event_request), 16'h0001, "capture request");
      wr(`RTCT_OFS_MAIN_CTRL, 8'h00);
      dir_up <= 1'b1;
      // Counter select: falls on the shared pin step the count
      wr(`RTCT_OFS_CNT_LO, 8'h00);
      wr(`RTCT_OFS_CNT_HI, 8'h00);
      wr(`RTCT_OFS_MAIN_CTRL, 8'h06);
      repeat (3) begin
         @(posedge sys_clk) ext_drive[2] <= 1'b0;
         @(posedge sys_clk) ext_drive[2] <= 1'b1;
      end
      @(posedge sys_clk) #1 chk(count_value, 16'h0003, "pin falls counted");
      // Clock out with a 16-step rollover period
      wr(`RTCT_OFS_MODE_CTRL, 8'h02);
      wr(`RTCT_OFS_RLD_LO, 8'hF0);
      wr(`RTCT_OFS_RLD_HI, 8'hFF);
      wr(`RTCT_OFS_CNT_LO, 8'hF0);
      wr(`RTCT_OFS_CNT_HI, 8'hFF);
      wr(`RTCT_OFS_MAIN_CTRL, 8'h04);
      watch(640);
      chk(16'(pin_oe_n[2]), 16'h0000, "clock pin driven");
      rng(tg, 16'd39, 16'd41, "clock out toggles");
      rd(`RTCT_OFS_MAIN_CTRL);
      chk(16'(d[7]), 16'h0000, "no flag in clock out");
      // Baud for UART A rx and UART B tx only, clock out kept running
      wr(`RTCT_OFS_MODE_CTRL, 8'h12);
      wr(`RTCT_OFS_MAIN_CTRL, 8'h24);
      watch(2560);
      rng(tg, 16'd159, 16'd161, "baud count rate");
      rng(t0, 16'd9, 16'd11, "uart a rx ticks");
      rng(t3, 16'd9, 16'd11, "uart b tx ticks");
      chk(m, 16'h0000, "default ticks kept");
      rd(`RTCT_OFS_MAIN_CTRL);
      chk(16'(d[7]), 16'h0000, "no flag in baud");
      // Reset in mid-run drops every mode and hands the pins back to the port
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`RTCT_OFS_MAIN_CTRL);
      chk(16'(d), 16'h0000, "main ctrl after reset");
      chk(16'(pin_oe_n), 16'(port_oe_n), "pins released by reset");
      report_and_stop();
   end
endmodule : rtct_timer_tb
`default_nettype wire
